// ### logic/urxw_pkg.sv
package urxw_pkg;
  // register byte offsets
  localparam logic [7:0] URXW_CTRL_OFS = 8'h00;
  localparam logic [7:0] URXW_IE_OFS = 8'h04;
  localparam logic [7:0] URXW_STAT_OFS = 8'h08;
  localparam logic [7:0] URXW_DATA_OFS = 8'h0C;
  localparam logic [7:0] URXW_DIV_OFS = 8'h10;
  // control register fields
  localparam int URXW_CTL_RE = 0;
  localparam int URXW_CTL_M = 1;
  localparam int URXW_CTL_WAKE = 2;
  localparam int URXW_CTL_IDLE_COUNT_START_SELECT = 3;
  localparam int URXW_CTL_PEN = 4;
  localparam int URXW_CTL_PTY = 5;
  localparam int URXW_CTL_RWU = 6;
  localparam int URXW_CTL_BCE = 7;
  // reset values
  localparam logic [7:0] URXW_CTRL_RST = 8'h00;
  localparam logic [15:0] URXW_DIV_RST = 16'h0000;
  // sample-clock slots within one bit time
  localparam logic [4:0] URXW_RT_EDGE = 5'h02;
  localparam logic [4:0] URXW_RT_ST_A = 5'h03;
  localparam logic [4:0] URXW_RT_ST_B = 5'h05;
  localparam logic [4:0] URXW_RT_ST_C = 5'h07;
  localparam logic [4:0] URXW_RT_DA = 5'h08;
  localparam logic [4:0] URXW_RT_DB = 5'h09;
  localparam logic [4:0] URXW_RT_DC = 5'h0A;
  localparam logic [4:0] URXW_RT_BIT = 5'h10;
  // stop bit index, start bit is index 0
  localparam logic [3:0] URXW_STOP8 = 4'h9;
  localparam logic [3:0] URXW_STOP9 = 4'hA;
  // idle character length in sample cycles
  localparam logic [7:0] URXW_IDLE8 = 8'(10 * 16);
  localparam logic [7:0] URXW_IDLE9 = 8'(11 * 16);
  // bus responses
  localparam logic [1:0] URXW_OKAY = 2'h0;
  localparam logic [1:0] URXW_SLVERR = 2'h2;
  localparam logic [1:0] URXW_DECERR = 2'h3;

  typedef struct packed {
    logic pe;
    logic fe;
    logic nf;
    logic ovr;
    logic idle;
    logic rf;
  } urxw_flags_t;

  typedef enum {URXW_SRCH, URXW_CHAR} urxw_state_t;
endpackage

// ### logic/urxw_rx.sv
`timescale 1ns/1ns
module urxw_rx
  import urxw_pkg::*;
#(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // axi4-lite write
  input wire logic s_awvalid_in,
  input wire logic [AW-1:0] s_awaddr_in,
  output logic s_awready_out,
  input wire logic s_wvalid_in,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  output logic s_wready_out,
  output logic s_bvalid_out,
  output logic [1:0] s_bresp_out,
  input wire logic s_bready_in,
  // axi4-lite read
  input wire logic s_arvalid_in,
  input wire logic [AW-1:0] s_araddr_in,
  output logic s_arready_out,
  output logic s_rvalid_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  input wire logic s_rready_in,
  // serial line and system
  input wire logic rx_in,
  input wire logic break_in,
  input wire logic wait_in,
  output logic rx_irq_out,
  output logic err_irq_out,
  output logic wake_out
);

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0] ofs);
    hit = (a == AW'(ofs));
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    wmerge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic noisy(input logic [2:0] s);
    noisy = (|s) & ~(&s);
  endfunction

  logic [7:0] ctrl_r;
  logic [15:0] div_r;
  logic [15:0] div_cnt_r;
  logic tick_r;
  urxw_flags_t ie_r;
  urxw_flags_t flags_r;
  urxw_flags_t arm_r;
  urxw_flags_t set_c;
  urxw_flags_t clr_c;
  logic [8:0] data_r;
  urxw_state_t st_r;
  logic [2:0] hist_r;
  logic [2:0] stv_r;
  logic [2:0] smp_r;
  logic [4:0] rt_r;
  logic [3:0] bit_r;
  logic [8:0] sh_r;
  logic noise_r;
  logic prev_r;
  logic [7:0] idle_cnt_r;
  logic idle_arm_r;
  logic wake_d_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_have_r;
  logic w_have_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic rx_irq_r;
  logic err_irq_r;
  logic wake_r;

  logic re;
  logic m9;
  logic wake_sel;
  logic idle_count_start_select;
  logic standby_request_bit;
  logic bce;
  logic [2:0] s3_c;
  logic eval_c;
  logic done_c;
  logic [3:0] lastb_c;
  logic [8:0] dat_c;
  logic perr_c;
  logic msb_c;
  logic [7:0] lim_c;
  logic cnt_en_c;
  logic idle_evt_c;
  logic idle_line_c;
  logic drop_c;
  logic wake_hit_c;
  logic eff_c;
  logic wr_go;
  logic wr_ok;
  logic rd_go;
  logic rd_ok;
  logic [31:0] rd_val_c;
  logic rd_map_c;
  logic wr_map_c;
  logic rxirq_c;
  logic errirq_c;

  assign re = ctrl_r[URXW_CTL_RE];
  assign m9 = ctrl_r[URXW_CTL_M];
  assign wake_sel = ctrl_r[URXW_CTL_WAKE];
  assign idle_count_start_select = ctrl_r[URXW_CTL_IDLE_COUNT_START_SELECT];
  assign standby_request_bit = ctrl_r[URXW_CTL_RWU];
  assign bce = ctrl_r[URXW_CTL_BCE];

  // sample clock: one tick per (div+1) system clocks
  always_ff @(posedge clk_in) begin
    if (rst_in || div_cnt_r == div_r) begin
      div_cnt_r <= 16'h0000;
      tick_r <= !rst_in;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  always_comb begin
    s3_c = {smp_r[1:0], rx_in};
    eval_c = tick_r && st_r == URXW_CHAR && rt_r == URXW_RT_DC;
    lastb_c = m9 ? URXW_STOP9 : URXW_STOP8;
    done_c = eval_c && bit_r == lastb_c;
    dat_c = m9 ? sh_r : {1'b0, sh_r[8:1]};
    perr_c = ctrl_r[URXW_CTL_PEN] && ((^dat_c) != ctrl_r[URXW_CTL_PTY]);
    msb_c = m9 ? dat_c[8] : dat_c[7];
    lim_c = m9 ? URXW_IDLE9 : URXW_IDLE8;
    // ones inside a character count only when counting after start
    cnt_en_c = st_r == URXW_SRCH || (!idle_count_start_select && bit_r != 4'h0);
    idle_evt_c = re && tick_r && rx_in && cnt_en_c &&
                 idle_cnt_r == lim_c - 8'h01;
    idle_line_c = idle_cnt_r == lim_c;
    drop_c = standby_request_bit && !(wake_sel && msb_c);
    wake_hit_c = standby_request_bit && ((done_c && wake_sel && msb_c) ||
                 (!wake_sel && (idle_evt_c ||
                 (wake_d_r && idle_line_c))));
  end

  // receive sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in || !re) begin
      st_r <= URXW_SRCH;
      hist_r <= 3'h0;
      stv_r <= 3'h0;
      smp_r <= 3'h0;
      rt_r <= 5'h00;
      bit_r <= 4'h0;
      sh_r <= 9'h000;
      noise_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (tick_r) begin
      hist_r <= {hist_r[1:0], rx_in};
      case (st_r)
        URXW_SRCH: begin
          if (!rx_in && hist_r == 3'h7) begin
            st_r <= URXW_CHAR;
            rt_r <= URXW_RT_EDGE;
            bit_r <= 4'h0;
            noise_r <= 1'b0;
          end
        end
        URXW_CHAR: begin
          rt_r <= rt_r + 5'h01;
          if (rt_r == URXW_RT_ST_A || rt_r == URXW_RT_ST_B) begin
            stv_r <= {stv_r[1:0], rx_in};
          end
          if (rt_r == URXW_RT_DA || rt_r == URXW_RT_DB) begin
            smp_r <= {smp_r[1:0], rx_in};
          end
          if (bit_r == 4'h0 && rt_r == URXW_RT_ST_C) begin
            if (maj3({stv_r[1:0], rx_in})) begin
              st_r <= URXW_SRCH;
            end else begin
              noise_r <= noise_r | (|{stv_r[1:0], rx_in});
            end
          end
          if (rt_r == URXW_RT_DC) begin
            prev_r <= maj3(s3_c);
            noise_r <= noise_r | (bit_r == 4'h0 ? |s3_c : noisy(s3_c));
            if (bit_r != 4'h0 && bit_r != lastb_c) begin
              sh_r <= {maj3(s3_c), sh_r[8:1]};
            end
            if (bit_r == lastb_c) begin
              st_r <= URXW_SRCH;
            end
          end
          if (rt_r == URXW_RT_BIT) begin
            rt_r <= 5'h01;
            bit_r <= bit_r + 4'h1;
          end else if (rt_r > URXW_RT_DC && bit_r != 4'h0 &&
                       bit_r != lastb_c && prev_r && hist_r[0] &&
                       !rx_in) begin
            // early edge realigns the next bit
            rt_r <= URXW_RT_EDGE;
            bit_r <= bit_r + 4'h1;
          end else if (rt_r >= URXW_RT_EDGE && rt_r < URXW_RT_DA &&
                       bit_r != 4'h0 && bit_r != lastb_c && prev_r &&
                       hist_r[0] && !rx_in) begin
            // late edge: slow sender, this tick is slot one again
            rt_r <= URXW_RT_EDGE;
          end
        end
        default: st_r <= URXW_SRCH;
      endcase
    end
  end

  // idle line counting
  always_ff @(posedge clk_in) begin
    if (rst_in || !re) begin
      idle_cnt_r <= 8'h00;
      idle_arm_r <= 1'b0;
    end else begin
      if (tick_r) begin
        if (!rx_in) begin
          idle_cnt_r <= 8'h00;
        end else if (cnt_en_c && !idle_line_c) begin
          idle_cnt_r <= idle_cnt_r + 8'h01;
        end
      end
      if (done_c) begin
        idle_arm_r <= 1'b1;
      end else if (idle_evt_c) begin
        idle_arm_r <= 1'b0;
      end
    end
  end

  // flag events and the two-step clear
  always_comb begin
    set_c = '0;
    if (done_c && !drop_c) begin
      if (flags_r.rf) begin
        set_c.ovr = 1'b1;
      end else begin
        set_c.rf = 1'b1;
        set_c.fe = !maj3(s3_c);
        set_c.nf = noise_r | noisy(s3_c);
        set_c.pe = perr_c;
      end
    end
    // waking idle is absorbed by rwu here
    set_c.idle = idle_evt_c && idle_arm_r && !standby_request_bit;
    eff_c = !break_in || bce;
    clr_c = (rd_ok && eff_c && hit(s_araddr_in, URXW_DATA_OFS)) ?
            arm_r : '0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_r <= '0;
      arm_r <= '0;
    end else begin
      // set beats a clear in the same cycle
      flags_r <= (flags_r & ~clr_c) | set_c;
      if (rd_ok && eff_c && hit(s_araddr_in, URXW_STAT_OFS)) begin
        arm_r <= flags_r;
      end else if (rd_ok && eff_c && hit(s_araddr_in, URXW_DATA_OFS)) begin
        arm_r <= '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_r <= 9'h000;
    end else if (done_c && !drop_c && !flags_r.rf) begin
      data_r <= dat_c;
    end
  end

  // control and configuration registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= URXW_CTRL_RST;
      ie_r <= '0;
      div_r <= URXW_DIV_RST;
      wake_d_r <= 1'b0;
    end else begin
      wake_d_r <= wake_sel;
      if (wr_ok && hit(awaddr_r, URXW_CTRL_OFS)) begin
        ctrl_r <= 8'(wmerge({24'h00_0000, ctrl_r}, wdata_r, wstrb_r));
      end else if (wake_hit_c) begin
        ctrl_r[URXW_CTL_RWU] <= 1'b0;
      end
      if (wr_ok && hit(awaddr_r, URXW_IE_OFS)) begin
        ie_r <= 6'(wmerge({26'h000_0000, ie_r}, wdata_r, wstrb_r));
      end
      if (wr_ok && hit(awaddr_r, URXW_DIV_OFS)) begin
        div_r <= 16'(wmerge({16'h0000, div_r}, wdata_r, wstrb_r));
      end
    end
  end

  // interrupt requests
  always_comb begin
    rxirq_c = !standby_request_bit && ((flags_r.rf && ie_r.rf) ||
              (flags_r.idle && ie_r.idle));
    errirq_c = !standby_request_bit && |({flags_r.ovr, flags_r.nf, flags_r.fe,
               flags_r.pe} & {ie_r.ovr, ie_r.nf, ie_r.fe, ie_r.pe});
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_irq_r <= 1'b0;
      err_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      rx_irq_r <= rxirq_c;
      err_irq_r <= errirq_c;
      wake_r <= wait_in && (rxirq_c || errirq_c);
    end
  end

  // axi4-lite write channel
  assign wr_go = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ok = wr_go && !wait_in;
  assign wr_map_c = hit(awaddr_r, URXW_CTRL_OFS) ||
                    hit(awaddr_r, URXW_IE_OFS) ||
                    hit(awaddr_r, URXW_DIV_OFS);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= URXW_OKAY;
    end else begin
      if (s_awvalid_in && awready_r) begin
        awaddr_r <= s_awaddr_in;
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_wvalid_in && wready_r) begin
        wdata_r <= s_wdata_in;
        wstrb_r <= s_wstrb_in;
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wait_in ? URXW_SLVERR :
                   (wr_map_c ? URXW_OKAY : URXW_DECERR);
      end
      if (bvalid_r && s_bready_in) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // axi4-lite read channel; status and data reads have side effects
  assign rd_go = s_arvalid_in && arready_r;
  assign rd_ok = rd_go && !wait_in;

  always_comb begin
    rd_map_c = 1'b1;
    rd_val_c = 32'h0000_0000;
    if (hit(s_araddr_in, URXW_CTRL_OFS)) begin
      rd_val_c = {24'h00_0000, ctrl_r};
    end else if (hit(s_araddr_in, URXW_IE_OFS)) begin
      rd_val_c = {26'h000_0000, ie_r};
    end else if (hit(s_araddr_in, URXW_STAT_OFS)) begin
      rd_val_c = {25'h000_0000, st_r == URXW_CHAR, flags_r};
    end else if (hit(s_araddr_in, URXW_DATA_OFS)) begin
      rd_val_c = {23'h00_0000, data_r};
    end else if (hit(s_araddr_in, URXW_DIV_OFS)) begin
      rd_val_c = {16'h0000, div_r};
    end else begin
      rd_map_c = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= URXW_OKAY;
    end else begin
      if (rd_go) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= wait_in ? 32'h0000_0000 : rd_val_c;
        rresp_r <= wait_in ? URXW_SLVERR :
                   (rd_map_c ? URXW_OKAY : URXW_DECERR);
      end else if (rvalid_r && s_rready_in) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign s_awready_out = awready_r;
  assign s_wready_out = wready_r;
  assign s_bvalid_out = bvalid_r;
  assign s_bresp_out = bresp_r;
  assign s_arready_out = arready_r;
  assign s_rvalid_out = rvalid_r;
  assign s_rdata_out = rdata_r;
  assign s_rresp_out = rresp_r;
  assign rx_irq_out = rx_irq_r;
  assign err_irq_out = err_irq_r;
  assign wake_out = wake_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  stop_slot_a: assert property (done_c |->
    rt_r == URXW_RT_DC && bit_r == (m9 ? 4'hA : 4'h9))
    else $error("stop sampled at wrong slot");
  fe_with_rf_a: assert property ($rose(flags_r.fe) |->
    $rose(flags_r.rf))
    else $error("framing flag without receive full");
  ovr_keep_a: assert property ($rose(flags_r.ovr) |->
    $stable(data_r) && flags_r.rf)
    else $error("overrun changed buffer");
  standby_mute_a: assert property (standby_request_bit |=>
    !rx_irq_out && !err_irq_out)
    else $error("interrupt during standby");
  addr_wake_a: assert property (done_c && standby_request_bit && wake_sel &&
    msb_c && !wr_ok && !flags_r.rf |=> !standby_request_bit && flags_r.rf)
    else $error("address mark did not wake");
  idle_wake_a: assert property (standby_request_bit && !wake_sel && idle_evt_c &&
    !wr_ok |=> !standby_request_bit && $stable(flags_r.idle))
    else $error("idle wake misbehaved");
  err_irq_a: assert property (!standby_request_bit && flags_r.fe && ie_r.fe
    |=> err_irq_out)
    else $error("error request missing");
  break_hold_a: assert property (break_in && !bce |=>
    (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag cleared in break");
  wait_refuse_a: assert property (rd_go && wait_in |=>
    rvalid_r && rresp_r == URXW_SLVERR)
    else $error("read not refused in wait");

  char_done_c: cover property (done_c && !drop_c);
  overrun_c: cover property ($rose(flags_r.ovr));
  idle_wake_c: cover property (standby_request_bit && !wake_sel && idle_evt_c);
  resync_c: cover property (tick_r && st_r == URXW_CHAR &&
    rt_r > URXW_RT_DC && prev_r && hist_r[0] && !rx_in);

endmodule

// ### sim/urxw_tx_model.sv
`timescale 1ns/1ns
module urxw_tx_model (
  // clock
  input wire logic clk_in,
  // character request
  input wire logic go_in,
  input wire logic [8:0] data_in,
  input wire logic [3:0] nbits_in,
  input wire logic [4:0] bit_clks_in,
  input wire logic stop_lvl_in,
  // serial line
  output logic tx_out,
  output logic busy_out
);
  logic [9:0] sh_r;
  logic [3:0] left_r;
  logic [4:0] cnt_r;

  initial begin
    tx_out = 1'b1;
    busy_out = 1'b0;
    sh_r = '0;
    left_r = '0;
    cnt_r = '0;
  end

  // bit length off sixteen gives a slow or fast sender
  always @(posedge clk_in) begin
    if (!busy_out) begin
      if (go_in) begin
        sh_r <= 10'(data_in) | (10'(stop_lvl_in) << nbits_in);
        tx_out <= 1'b0;
        left_r <= nbits_in + 4'h1;
        cnt_r <= 5'h01;
        busy_out <= 1'b1;
      end
    end else if (cnt_r != bit_clks_in) begin
      cnt_r <= cnt_r + 5'h01;
    end else if (left_r == 4'h0) begin
      // idle high again, also after a zero stop bit
      tx_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      tx_out <= sh_r[0];
      sh_r <= sh_r >> 1;
      left_r <= left_r - 4'h1;
      cnt_r <= 5'h01;
    end
  end
endmodule

// ### sim/urxw_testbench.sv
`timescale 1ns/1ns
module testbench
  import urxw_pkg::*;
;
  logic clk_in, rst_in, awv, wv, bry, arv, rry, brk, wt, rx;
  logic awr, wr_r, bv, ar, rv, rx_irq, err_irq, wake, tx_go, tx_sl, tx_busy;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr;
  logic [8:0] tx_d;
  logic [3:0] tx_nb;
  logic [4:0] tx_bc;
  int n_fail, n_compared, cyc;

  urxw_rx i_dut (.clk_in(clk_in), .rst_in(rst_in), .s_awvalid_in(awv),
    .s_awaddr_in(awa), .s_awready_out(awr), .s_wvalid_in(wv),
    .s_wdata_in(wd), .s_wstrb_in(4'hF), .s_wready_out(wr_r),
    .s_bvalid_out(bv), .s_bresp_out(br), .s_bready_in(bry),
    .s_arvalid_in(arv), .s_araddr_in(ara), .s_arready_out(ar),
    .s_rvalid_out(rv), .s_rdata_out(rdat), .s_rresp_out(rr),
    .s_rready_in(rry), .rx_in(rx), .break_in(brk), .wait_in(wt),
    .rx_irq_out(rx_irq), .err_irq_out(err_irq), .wake_out(wake));
  urxw_tx_model i_tx (.clk_in(clk_in), .go_in(tx_go), .data_in(tx_d),
    .nbits_in(tx_nb), .bit_clks_in(tx_bc), .stop_lvl_in(tx_sl),
    .tx_out(rx), .busy_out(tx_busy));

  always #25 clk_in = ~clk_in;

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under this
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge clk_in);
      if (awr === 1'b1) ad = 1'b1;
      if (wr_r === 1'b1) dd = 1'b1;
      @(posedge clk_in);
      if (ad) awv <= 1'b0;
      if (dd) wv <= 1'b0;
    end
    @(negedge clk_in);
    while (bv !== 1'b1) @(negedge clk_in);
    chk("bresp", 32'(er), 32'(br));
    @(posedge clk_in);
    bry <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    @(negedge clk_in);
    while (ar !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    arv <= 1'b0;
    @(negedge clk_in);
    while (rv !== 1'b1) @(negedge clk_in);
    d = rdat;
    chk("rresp", 32'(er), 32'(rr));
    @(posedge clk_in);
    rry <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e, m);
    rd(a, URXW_OKAY);
    chk(nm, e, d & m);
  endtask

  task automatic irqs(input logic [2:0] e);
    @(negedge clk_in);
    chk("wake err rx", 32'(e), 32'({wake, err_irq, rx_irq}));
    @(posedge clk_in);
  endtask

  task automatic send(input logic [8:0] v, input logic [3:0] nb,
                      input logic [4:0] bc, input logic sl);
    tx_d <= v;
    tx_nb <= nb;
    tx_bc <= bc;
    tx_sl <= sl;
    tx_go <= 1'b1;
    @(posedge clk_in);
    tx_go <= 1'b0;
    @(negedge clk_in);
    while (tx_busy === 1'b1) @(negedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask

  task automatic s8(input logic [8:0] v);
    send(v, 4'h8, 5'h10, 1'b1);
  endtask

  task automatic clr();
    rd(URXW_STAT_OFS, URXW_OKAY);
    rd(URXW_DATA_OFS, URXW_OKAY);
  endtask

  task automatic setup(input logic [31:0] c, ie);
    wr(URXW_IE_OFS, ie, URXW_OKAY);
    wr(URXW_CTRL_OFS, c, URXW_OKAY);
  endtask

  task automatic t_regs();
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rdc("div", URXW_DIV_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(URXW_STAT_OFS, 32'h0000_003F, URXW_DECERR);
    wr(8'h20, 32'h0000_0001, URXW_DECERR);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0000, 32'h0000_003F);
  endtask

  task automatic t_basic();
    setup(32'h0000_0001, 32'h0000_0003);
    s8(9'h0A5);
    irqs(3'b001);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0001, 32'h0000_003F);
    rdc("data", URXW_DATA_OFS, 32'h0000_00A5, 32'h0000_01FF);
    irqs(3'b000);
    repeat (200) @(posedge clk_in);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0002, 32'h0000_003F);
    irqs(3'b001);
    rd(URXW_DATA_OFS, URXW_OKAY);
  endtask

  task automatic t_errs();
    setup(32'h0000_0001, 32'h0000_0004);
    s8(9'h011);
    s8(9'h022);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0005, 32'h0000_003F);
    irqs(3'b010);
    rdc("data", URXW_DATA_OFS, 32'h0000_0011, 32'h0000_01FF);
    irqs(3'b000);
    wr(URXW_IE_OFS, 32'h0000_0010, URXW_OKAY);
    send(9'h033, 4'h8, 5'h10, 1'b0);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0011, 32'h0000_003F);
    irqs(3'b010);
    rd(URXW_DATA_OFS, URXW_OKAY);
    setup(32'h0000_0011, 32'h0000_0020);
    s8(9'h083);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0021, 32'h0000_003F);
    irqs(3'b010);
    rd(URXW_DATA_OFS, URXW_OKAY);
  endtask

  task automatic t_tol();
    logic [4:0] bcs [2];
    bcs = '{5'h11, 5'h0F};
    setup(32'h0000_0001, 32'h0000_0000);
    foreach (bcs[i]) begin
      send(9'h055, 4'h8, bcs[i], 1'b1);
      rdc("stat", URXW_STAT_OFS, 32'h0000_0001, 32'h0000_003F);
      rdc("data", URXW_DATA_OFS, 32'h0000_0055, 32'h0000_01FF);
    end
    wr(URXW_CTRL_OFS, 32'h0000_0003, URXW_OKAY);
    send(9'h1A5, 4'h9, 5'h10, 1'b1);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0001, 32'h0000_003F);
    rdc("data", URXW_DATA_OFS, 32'h0000_01A5, 32'h0000_01FF);
  endtask

  task automatic t_stby();
    setup(32'h0000_0045, 32'h0000_0001);
    s8(9'h001);
    irqs(3'b000);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0000, 32'h0000_003F);
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0045, 32'h0000_00FF);
    s8(9'h081);
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0005, 32'h0000_00FF);
    irqs(3'b001);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0001, 32'h0000_003F);
    rdc("data", URXW_DATA_OFS, 32'h0000_0081, 32'h0000_01FF);
    repeat (200) @(posedge clk_in);
    // wake select falls on an idle line: wakes at once
    wr(URXW_CTRL_OFS, 32'h0000_0049, URXW_OKAY);
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0009, 32'h0000_00FF);
    clr();
    wr(URXW_CTRL_OFS, 32'h0000_0049, URXW_OKAY);
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0049, 32'h0000_00FF);
    s8(9'h011);
    repeat (200) @(posedge clk_in);
    rdc("ctrl", URXW_CTRL_OFS, 32'h0000_0009, 32'h0000_00FF);
    rdc("stat", URXW_STAT_OFS, 32'h0000_0000, 32'h0000_003F);
  endtask

  task automatic t_wait_brk();
    setup(32'h0000_0001, 32'h0000_0001);
    wt <= 1'b1;
    rd(URXW_STAT_OFS, URXW_SLVERR);
    chk("wait data", 32'h0000_0000, d);
    s8(9'h03C);
    irqs(3'b101);
    wt <= 1'b0;
    @(posedge clk_in);
    rd(URXW_STAT_OFS, URXW_OKAY);
    brk <= 1'b1;
    clr();
    irqs(3'b001);
    brk <= 1'b0;
    irqs(3'b001);
    rd(URXW_DATA_OFS, URXW_OKAY);
    irqs(3'b000);
    wr(URXW_CTRL_OFS, 32'h0000_0081, URXW_OKAY);
    s8(9'h05A);
    brk <= 1'b1;
    clr();
    brk <= 1'b0;
    irqs(3'b000);
  endtask

  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {awv, wv, bry, arv, rry, brk, wt, tx_go, tx_sl} = '0;
    {awa, ara, wd, tx_d, tx_nb, tx_bc} = '0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_basic();
    t_errs();
    t_tol();
    t_stby();
    t_wait_brk();
    end_of_test();
  end
endmodule
